/* tb_thermal_reading_formatter.sv */
// testbench for the thermal reading formatter
`timescale 1ns/1ps
module tb_thermal_reading_formatter;
   logic        mclk = 0, rst = 1, sampleValid = 0, generalSensorFault = 0, sensorUnderflow = 0, filterRestart = 0;
   logic [15:0] sample = 16'h0000, temperature;
   logic [3:0]  averagingConstant = 4'h0;
   logic        temperatureValid, temperatureUpdated, isReading;
   logic [7:0]  thermalStatus;
   int          numErrors = 0, checksDone = 0;
   thermal_reading_formatter thermal_reading_formatter_i (
      .mclk               (mclk),
      .rst                (rst),
      .sampleValid        (sampleValid),
      .sample             (sample),
      .generalSensorFault (generalSensorFault),
      .sensorUnderflow    (sensorUnderflow),
      .averagingConstant  (averagingConstant),
      .filterRestart      (filterRestart),
      .temperature        (temperature),
      .temperatureValid   (temperatureValid),
      .temperatureUpdated (temperatureUpdated),
      .thermalStatus      (thermalStatus)
   );
   trf_originator_model trf_originator_model_i (
      .mclk               (mclk),
      .temperature        (temperature),
      .temperatureUpdated (temperatureUpdated),
      .isReading          (isReading)
   );
   initial forever #12.5 mclk = ~mclk;
   task chk(input string n, input logic [15:0] got, exp);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %s expected %h seen %h", n, exp, got);
      end
   endtask
   task put(input logic [15:0] s, input logic [3:0] x, input logic f, u, r);
      {sample, averagingConstant, generalSensorFault, sensorUnderflow, filterRestart} = {s, x, f, u, r};
      sampleValid = 1;
      @(posedge mclk) #2;
      chk("updated", temperatureUpdated, 1);
   endtask
   task idle;
      sampleValid = 0;
      @(posedge mclk) #2;
      chk("pulse", temperatureUpdated, 0);
   endtask
   task t_pass;
      put(16'hFD80, 0, 0, 0, 1);
      chk("temp", temperature, 16'hFD80);
      chk("status", thermalStatus, 8'hF6);
      idle;
   endtask
   task t_filter;
      put(16'hFD80, 0, 0, 0, 1);
      put(16'hFF00, 1, 0, 0, 0);
      chk("avg1", temperature, 16'hFE40);
      put(16'hFF00, 1, 0, 0, 0);
      chk("avg2", temperature, 16'hFEA0);
      idle;
      chk("hold", temperature, 16'hFEA0);
   endtask
   task t_codes;
      put(16'hFE00, 0, 1, 1, 0);
      chk("fault", temperature, 16'h8000);
      put(16'hFE00, 0, 0, 1, 0);
      chk("under", temperature, 16'h8002);
      chk("valid", temperatureValid, 0);
      idle;
      chk("class", isReading, 0);
      put(16'hFE00, 3, 0, 0, 0);
      chk("reseed", temperature, 16'hFE00);
      chk("valid", temperatureValid, 1);
      idle;
   endtask
   task t_range;
      put(16'h0040, 0, 0, 0, 1);
      chk("pos", temperature, 16'hFFFF);
      put(16'h8100, 0, 0, 0, 1);
      chk("rsv", temperature, 16'h8200);
      idle;
      chk("class", isReading, 1);
   endtask
   task t_reset;
      put(16'hFD80, 0, 0, 0, 1);
      sampleValid = 0;
      rst = 1;
      @(posedge mclk) #2;
      chk("rsttemp", temperature, 16'h8000);
      chk("rstvalid", temperatureValid, 0);
      chk("rststat", thermalStatus, 8'h00);
      chk("rstpulse", temperatureUpdated, 0);
      rst = 0;
      put(16'hFE00, 1, 0, 0, 0);
      chk("seed", temperature, 16'hFE00);
      idle;
   endtask
   task finalReport;
      $display("errors %0d checks %0d", numErrors, checksDone);
      if (numErrors == 0 && checksDone > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      #100us;
      numErrors++;
      finalReport;
   end
   initial begin
      repeat (4) @(posedge mclk);
      #2 rst = 0;
      chk("rtemp", temperature, 16'h8000);
      chk("rstat", thermalStatus, 8'h00);
      t_pass;
      t_filter;
      t_codes;
      t_range;
      t_reset;
      finalReport;
   end
endmodule // tb_thermal_reading_formatter

/* thermal_reading_formatter.sv */
// thermal reading formatter: smooths sensor samples and encodes the response word
//
// Behaviour
// - reported temperature is 16-bit two's complement in 1/64 degree counts
// - sign in top bit, integer 0..511 field below, fraction in low six bits
// - status register view returns only bits 13..6 of the reported word
// - good samples are low-pass filtered (first, post-fault or restart samples seed it), output kept at 1/64 degree resolution
// - new average = old*(1-alpha) + sample*alpha, alpha = 1/2^X
// - readings are offsets below throttle threshold; valid ones are never positive
// - general sensor fault reports code 0x8000
// - working sensor below its range reports code 0x8002
// - 0x8001 and 0x8003..0x81FF reserved for errors, never temperatures
`timescale 1ns/1ps
`include "trf_params.svh"

module thermal_reading_formatter (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst,
   // sensor sample source
   input  wire logic                      sampleValid,
   input  wire logic [`TRF_WORD_W-1:0]    sample,
   input  wire logic                      generalSensorFault,
   input  wire logic                      sensorUnderflow,
   // configuration
   input  wire logic [`TRF_SHIFT_W-1:0]   averagingConstant,
   input  wire logic                      filterRestart,
   // response path
   output      logic [`TRF_WORD_W-1:0]    temperature,
   output      logic                      temperatureValid,
   output      logic                      temperatureUpdated,
   output      logic [`TRF_STATUS_W-1:0]  thermalStatus
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a word in the reserved error band must never be reported as a reading
   function automatic logic inErrorBand(input logic [`TRF_WORD_W-1:0] w);
      inErrorBand = (w >= `TRF_ERR_LO) && (w <= `TRF_ERR_HI);
   endfunction

   // clamp a filtered word into the legal, non-positive reading range
   function automatic logic [`TRF_WORD_W-1:0] clampReading(input logic [`TRF_WORD_W-1:0] w);
      if (!w[`TRF_WORD_W-1])
         clampReading = (w == '0) ? w : `TRF_MAX_VALID;
      else if (inErrorBand(w))
         clampReading = `TRF_ERR_HI + 16'h0001;
      else
         clampReading = w;
   endfunction

   // whole-degree view handed to the status register
   function automatic logic [`TRF_STATUS_W-1:0] statusView(input logic [`TRF_WORD_W-1:0] w);
      statusView = w[`TRF_STATUS_HI:`TRF_STATUS_LO];
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   trf_pkg::trf_regs_t r;
   trf_pkg::trf_regs_t next_r;

   logic signed [`TRF_ACC_W-1:0] stepAcc;
   logic [`TRF_WORD_W-1:0]       filtWord;
   logic [`TRF_WORD_W-1:0]       legalSample;

   // sample is clamped before filtering so a stray positive code cannot drag the average
   assign legalSample = clampReading(sample);

   // ----------------------------------------------------------------
   // filter datapath
   // ----------------------------------------------------------------
   // limitation: large shifts move only the fraction bits for a while,
   // so the reported word lags a step change by many samples; this is the
   // price of keeping the full fraction instead of rounding each step
   trf_filter_step u_step (
      .prevAcc  (r.acc),
      .sample   (legalSample),
      .avgShift (averagingConstant),
      .nextAcc  (stepAcc)
   );

   // full 1/64 degree result is the integer part of the accumulator
   assign filtWord = stepAcc[`TRF_ACC_W-1 -: `TRF_WORD_W];

   // ----------------------------------------------------------------
   // sample qualification
   // ----------------------------------------------------------------
   logic takeFault;
   logic takeUnder;
   logic takeGood;
   logic seedFilter;
   logic stepFilter;

   // fault beats underflow, so at most one of these is high in a cycle
   assign takeFault  = sampleValid && generalSensorFault;
   assign takeUnder  = sampleValid && !generalSensorFault && sensorUnderflow;
   assign takeGood   = sampleValid && !generalSensorFault && !sensorUnderflow;
   // a restart, or no trusted history, loads the sample instead of averaging it
   assign seedFilter = filterRestart || (r.state != trf_pkg::TRF_VALID);
   assign stepFilter = takeGood && !seedFilter;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r         = r;
      next_r.updated = 1'b0;
      case (r.state)
         trf_pkg::TRF_EMPTY: begin
            // a fault needs no history, so every state handles it alike
            if (takeFault) begin
               next_r.state       = trf_pkg::TRF_FAULT;
               next_r.result      = `TRF_CODE_FAULT;
               next_r.resultValid = 1'b0;
               next_r.updated     = 1'b1;
            end else if (takeUnder) begin
               next_r.state       = trf_pkg::TRF_FAULT;
               next_r.result      = `TRF_CODE_UNDER;
               next_r.resultValid = 1'b0;
               next_r.updated     = 1'b1;
            end else if (takeGood) begin
               // first reading after reset has nothing to average against
               next_r.state       = trf_pkg::TRF_VALID;
               next_r.acc         = {legalSample, {`TRF_ACC_FRAC_W{1'b0}}};
               next_r.result      = legalSample;
               next_r.resultValid = 1'b1;
               next_r.updated     = 1'b1;
            end
         end
         trf_pkg::TRF_VALID: begin
            // only here is there history worth averaging
            if (takeFault) begin
               next_r.state       = trf_pkg::TRF_FAULT;
               next_r.result      = `TRF_CODE_FAULT;
               next_r.resultValid = 1'b0;
               next_r.updated     = 1'b1;
            end else if (takeUnder) begin
               next_r.state       = trf_pkg::TRF_FAULT;
               next_r.result      = `TRF_CODE_UNDER;
               next_r.resultValid = 1'b0;
               next_r.updated     = 1'b1;
            end else if (stepFilter) begin
               next_r.acc         = stepAcc;
               next_r.result      = clampReading(filtWord);
               next_r.resultValid = 1'b1;
               next_r.updated     = 1'b1;
            end else if (takeGood) begin
               // restart asked for: drop the history and load the sample
               next_r.state       = trf_pkg::TRF_VALID;
               next_r.acc         = {legalSample, {`TRF_ACC_FRAC_W{1'b0}}};
               next_r.result      = legalSample;
               next_r.resultValid = 1'b1;
               next_r.updated     = 1'b1;
            end
         end
         trf_pkg::TRF_FAULT: begin
            if (takeFault) begin
               next_r.state       = trf_pkg::TRF_FAULT;
               next_r.result      = `TRF_CODE_FAULT;
               next_r.resultValid = 1'b0;
               next_r.updated     = 1'b1;
            end else if (takeUnder) begin
               next_r.state       = trf_pkg::TRF_FAULT;
               next_r.result      = `TRF_CODE_UNDER;
               next_r.resultValid = 1'b0;
               next_r.updated     = 1'b1;
            end else if (takeGood) begin
               // history from before the fault is not trusted
               next_r.state       = trf_pkg::TRF_VALID;
               next_r.acc         = {legalSample, {`TRF_ACC_FRAC_W{1'b0}}};
               next_r.result      = legalSample;
               next_r.resultValid = 1'b1;
               next_r.updated     = 1'b1;
            end
         end
         default: begin
            next_r.state       = trf_pkg::TRF_EMPTY;
            next_r.acc         = '0;
            next_r.result      = `TRF_RESET_TEMP;
            next_r.resultValid = 1'b0;
            next_r.updated     = 1'b0;
         end
      endcase
      next_r.statusByte = statusView(next_r.result);
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      // the status view of the reset word is all zeros
      if (rst) begin
         r.state       <= trf_pkg::TRF_EMPTY;
         r.acc         <= '0;
         r.result      <= `TRF_RESET_TEMP;
         r.statusByte  <= '0;
         r.resultValid <= 1'b0;
         r.updated     <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output is a state flop, no logic after the register
   assign temperature        = r.result;
   assign temperatureValid   = r.resultValid;
   assign temperatureUpdated = r.updated;
   assign thermalStatus      = r.statusByte;

endmodule // thermal_reading_formatter

/* trf_asserts.sv */
// assertion checker for the thermal reading formatter ports
`timescale 1ns/1ps
module trf_asserts (
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // sample source
   input wire logic        sampleValid,
   input wire logic [15:0] sample,
   input wire logic        generalSensorFault,
   input wire logic        sensorUnderflow,
   input wire logic [3:0]  averagingConstant,
   input wire logic        filterRestart,
   // response path
   input wire logic [15:0] temperature,
   input wire logic        temperatureValid,
   input wire logic        temperatureUpdated,
   input wire logic [7:0]  thermalStatus
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_good;
      sampleValid && !generalSensorFault && !sensorUnderflow;
   endsequence
   property p_upd; sampleValid |=> temperatureUpdated; endproperty
   a_upd: assert property (p_upd) else $error("no update after sample");
   property p_hold; !sampleValid |=> $stable(temperature) && !temperatureUpdated; endproperty
   a_hold: assert property (p_hold) else $error("output moved without sample");
   property p_stat; thermalStatus == temperature[13:6]; endproperty
   a_stat: assert property (p_stat) else $error("status slice wrong");
   property p_gse; sampleValid && generalSensorFault |=> temperature == 16'h8000 && !temperatureValid; endproperty
   a_gse: assert property (p_gse) else $error("fault code wrong");
   property p_und; sampleValid && !generalSensorFault && sensorUnderflow |=> temperature == 16'h8002; endproperty
   a_und: assert property (p_und) else $error("underflow code wrong");
   property p_neg; temperatureValid |-> temperature[15] || temperature == 16'h0000; endproperty
   a_neg: assert property (p_neg) else $error("positive reading");
   property p_rsv; temperatureValid |-> temperature[15:9] != 7'h40; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved code as reading");
   property p_pass;
      s_good ##0 (averagingConstant == 4'h0 && sample[15] && sample[15:9] != 7'h40) |=> temperature == $past(sample);
   endproperty
   a_pass: assert property (p_pass) else $error("shift zero not passthrough");
endmodule // trf_asserts
bind thermal_reading_formatter trf_asserts trf_asserts_i (
   .mclk               (mclk),
   .rst                (rst),
   .sampleValid        (sampleValid),
   .sample             (sample),
   .generalSensorFault (generalSensorFault),
   .sensorUnderflow    (sensorUnderflow),
   .averagingConstant  (averagingConstant),
   .filterRestart      (filterRestart),
   .temperature        (temperature),
   .temperatureValid   (temperatureValid),
   .temperatureUpdated (temperatureUpdated),
   .thermalStatus      (thermalStatus)
);

/* trf_filter_step.sv */
// one step of the first-order low-pass filter
`timescale 1ns/1ps
`include "trf_params.svh"

module trf_filter_step (
   // operands
   input  wire logic signed [`TRF_ACC_W-1:0]    prevAcc,
   input  wire logic signed [`TRF_WORD_W-1:0]   sample,
   input  wire logic        [`TRF_SHIFT_W-1:0]  avgShift,
   // result
   output      logic signed [`TRF_ACC_W-1:0]    nextAcc
);
   logic signed [`TRF_ACC_W-1:0] sampleAcc;
   logic signed [`TRF_ACC_W-1:0] diff;

   // T_N = T_N-1 + (sample - T_N-1) >>> X, same as (1-a)T + aS with a = 2^-X
   always_comb begin
      sampleAcc = {sample, {`TRF_ACC_FRAC_W{1'b0}}};
      diff      = sampleAcc - prevAcc;
      nextAcc   = prevAcc + (diff >>> avgShift);
   end
endmodule // trf_filter_step

/* trf_originator_model.sv */
// reading side model: classifies each delivered word
`timescale 1ns/1ps
module trf_originator_model (
   input wire logic        mclk,
   input wire logic [15:0] temperature,
   input wire logic        temperatureUpdated,
   output     logic        isReading
);
   // error band words are never taken as temperatures
   always_ff @(posedge mclk) if (temperatureUpdated) isReading <= temperature[15:9] != 7'h40;
endmodule // trf_originator_model

/* trf_params.svh */
// constants for the thermal reading formatter
`ifndef TRF_PARAMS_SVH
`define TRF_PARAMS_SVH

`define TRF_WORD_W        16
`define TRF_ACC_FRAC_W    16
`define TRF_ACC_W         32
`define TRF_SHIFT_W       4
`define TRF_SHIFT_MAX     4'hF
`define TRF_CODE_FAULT    16'h8000
`define TRF_CODE_UNDER    16'h8002
`define TRF_ERR_LO        16'h8000
`define TRF_ERR_HI        16'h81FF
`define TRF_MAX_VALID     16'hFFFF
`define TRF_STATUS_HI     13
`define TRF_STATUS_LO     6
`define TRF_STATUS_W      8
`define TRF_RESET_TEMP    16'h8000

`endif

/* trf_pkg.sv */
// types for the thermal reading formatter
package trf_pkg;
   typedef enum logic [2:0] {
      TRF_EMPTY = 3'h1,
      TRF_VALID = 3'h2,
      TRF_FAULT = 3'h4
   } trf_state_t;

   typedef struct packed {
      trf_state_t  state;
      logic [31:0] acc;
      logic [15:0] result;
      logic [7:0]  statusByte;
      logic        resultValid;
      logic        updated;
   } trf_regs_t;
endpackage
